// *** bench/ptmr_props.sv ***
`timescale 1ns/1ps
// ********************************************************
// Port checker for the periodic timer.
// ********************************************************
module ptmr_props (
  input wire MCLK,
  input wire RST,
  input wire CE,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire TIMER_OUT,
  input wire TIMER_OUT_EN,
  input wire MATCH_A_FLAG,
  input wire PERIOD_MATCH_FLAG,
  input wire FLAG_CLR_A
);
  reg [7:0] c1_q;
  reg [9:0] ma_q;
  reg [9:0] per_q;
  reg [3:0] age_q;
  wire wr_go = WR && CE;
  wire calm = age_q == 4'hf;
  // Pin and period flag checks are judged only once the setup has been left alone for 15 cycles, so pipeline lag never fires them.
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      c1_q <= 8'h00;
      ma_q <= 10'h000;
      per_q <= 10'h000;
      age_q <= 4'h0;
    end else begin
      if (wr_go && ADDR == 3'h1) c1_q <= WDATA;
      if (wr_go && ADDR == 3'h4) ma_q[7:0] <= WDATA;
      if (wr_go && ADDR == 3'h5) ma_q[9:8] <= WDATA[1:0];
      if (wr_go && ADDR == 3'h6) per_q[7:0] <= WDATA;
      if (wr_go && ADDR == 3'h7) per_q[9:8] <= WDATA[1:0];
      if (wr_go) age_q <= 4'h0;
      else if (!calm) age_q <= age_q + 4'h1;
    end
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  AST_RD_IDLE: assert property (!$past(RD && CE) |-> RDATA == 8'h00)
    else $error("read data not idle");
  AST_HI_ZERO: assert property ($past(RD && CE && ADDR[0] && ADDR != 3'h1) |-> RDATA[7:2] == 6'h00)
    else $error("unused high bits not zero");
  AST_MA_BACK: assert property ($past(RD && CE && ADDR == 3'h4) |-> RDATA == ma_q[7:0])
    else $error("match A low byte wrong");
  AST_PER_BACK: assert property ($past(RD && CE && ADDR == 3'h7) |-> RDATA == {6'h00, per_q[9:8]})
    else $error("period high bits wrong");
  AST_TMR_PIN: assert property (calm && c1_q[7:6] == 2'h3 |-> !TIMER_OUT_EN)
    else $error("timer mode drives pin");
  AST_CMP_PIN: assert property (calm && c1_q[7:6] == 2'h0 |-> TIMER_OUT_EN)
    else $error("compare mode leaves pin undriven");
  AST_NO_P_FLAG: assert property (calm && c1_q[7] == c1_q[6] && c1_q[0] |-> !$rose(PERIOD_MATCH_FLAG))
    else $error("period flag raised under match A clear");
  AST_PIN_CAUSE: assert property (calm && c1_q[7:6] == 2'h0 && $changed(TIMER_OUT) |-> ##[0:1] MATCH_A_FLAG)
    else $error("pin moved without match A");
  AST_FLAG_HOLD: assert property (MATCH_A_FLAG && !FLAG_CLR_A |=> MATCH_A_FLAG)
    else $error("match A flag dropped");
  AST_FULL_DUTY: assert property (calm && c1_q[7:4] == 4'ha && per_q != 10'h000 && ma_q >= per_q |->
    TIMER_OUT == (c1_q[3] ^ c1_q[2])) else $error("full duty output not active");
  cover property (MATCH_A_FLAG && PERIOD_MATCH_FLAG);
  cover property (calm && c1_q[7:4] == 4'ha && $rose(TIMER_OUT));
  cover property (c1_q[7:4] == 4'hb && $fell(TIMER_OUT));
endmodule

// *** bench/test_periodic_timer_10bit.sv ***
`timescale 1ns/1ps
// ********************************************************
// Self-checking bench for the periodic timer.
// ********************************************************
module test_periodic_timer_10bit;
  reg mclk, rst, ce, wr, rd, sub_tick, ext, clr_a, clr_p;
  reg [2:0] addr;
  reg [7:0] wdata, v, c1;
  reg [31:0] seed;
  reg [31:0] pwm_cfgs;
  wire [7:0] rdata;
  wire pin, pin_en, fa, fp;
  integer fails, comparisons, i, a, p, n, h, e;
  ptmr_core ptmr_core_i (.MCLK(mclk), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SUB_TICK(sub_tick), .EXT_COUNT_PIN(ext), .TIMER_OUT(pin), .TIMER_OUT_EN(pin_en),
    .MATCH_A_FLAG(fa), .PERIOD_MATCH_FLAG(fp), .FLAG_CLR_A(clr_a), .FLAG_CLR_P(clr_p));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic [31:0] next_rand(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      next_rand = t ^ (t << 5);
    end
  endfunction
  // Count registers are read-only and stay at zero while stopped.
  function automatic [7:0] exp_rd(input integer ad, input [7:0] d);
    exp_rd = (ad < 4) ? 8'h00 : (ad % 2 == 1) ? (d & 8'h03) : d;
  endfunction
  function automatic integer pwm_hi(input [7:0] c, input integer a, input integer p);
    integer pp, act;
    begin
      pp = (p == 0) ? 1024 : p;
      act = (c[5:4] == 2'h2) ? ((a >= pp) ? pp : a) * 2 : c[4] * pp * 2;
      pwm_hi = c[2] ? pp * 2 - act : act;
    end
  endfunction
  task automatic check(input [15:0] seen, input [15:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic cyc(input integer k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic wr_reg(input [2:0] ad, input [7:0] d);
    begin
      @(posedge mclk);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
    end
  endtask
  task automatic rd_reg(input [2:0] ad, output [7:0] d);
    begin
      @(posedge mclk);
      addr <= ad;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task automatic cfg(input [7:0] c, input [9:0] ma, input [9:0] per);
    begin
      wr_reg(3'h0, 8'h10);
      wr_reg(3'h1, c);
      wr_reg(3'h4, ma[7:0]);
      wr_reg(3'h5, {6'h00, ma[9:8]});
      wr_reg(3'h6, per[7:0]);
      wr_reg(3'h7, {6'h00, per[9:8]});
      @(posedge mclk);
      clr_a <= 1'b1;
      clr_p <= 1'b1;
      @(posedge mclk);
      clr_a <= 1'b0;
      clr_p <= 1'b0;
      wr_reg(3'h0, 8'h18);
    end
  endtask
  task automatic cnt_max(output [7:0] m);
    reg [7:0] lo;
    begin
      m = 8'h00;
      repeat (16) begin
        rd_reg(3'h2, lo);
        if (lo > m) m = lo;
      end
    end
  endtask
  task automatic watch(input integer k, output integer ch, output integer hi);
    reg last;
    begin
      ch = 0;
      hi = 0;
      @(posedge mclk);
      #1 last = pin;
      repeat (k) begin
        @(posedge mclk);
        #1;
        if (pin !== last) ch = ch + 1;
        if (pin === 1'b1) hi = hi + 1;
        last = pin;
      end
    end
  endtask
  task automatic give_verdict;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #2000000;
    fails = fails + 1;
    give_verdict;
  end
  initial begin
    {rst, ce, wr, rd, sub_tick, ext, clr_a, clr_p} = 8'h c0;
    addr = 3'h0;
    wdata = 8'h00;
    seed = 32'd64;
    pwm_cfgs = 32'h9888aca8;
    fails = 0;
    comparisons = 0;
    cyc(4);
    rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      rd_reg(i[2:0], v);
      check(v, 16'h0000);
    end
    for (i = 2; i < 8; i = i + 1) begin
      seed = next_rand(seed);
      wr_reg(i[2:0], seed[7:0]);
      rd_reg(i[2:0], v);
      check(v, exp_rd(i, seed[7:0]));
    end
    // Toggle on match A with the period clearing the count.
    cfg(8'h30, 10'd3, 10'd6);
    cyc(30);
    check({fa, fp}, 16'h0003);
    cnt_max(v);
    check(v, 16'h0006);
    watch(70, n, h);
    check(n[15:0], 16'd10);
    cfg(8'h01, 10'd4, 10'd2);
    cyc(30);
    check({fa, fp}, 16'h0002);
    check(pin, 1'b0);
    cnt_max(v);
    check(v, 16'h0004);
    for (n = 1; n < 3; n = n + 1) begin
      c1 = (n == 1) ? 8'h18 : 8'h20;
      cfg(c1, 10'd20, 10'd0);
      cyc(2);
      check(pin, c1[3]);
      cyc(30);
      check(pin, !c1[3]);
    end
    cfg(8'h30, 10'd0, 10'd0);
    cyc(1100);
    check({fa, pin}, 16'h0000);
    cfg(8'hc0, 10'd2, 10'd4);
    cyc(30);
    check({pin_en, fa, fp}, 16'h0003);
    for (i = 0; i < 8; i = i + 1) begin
      seed = next_rand(seed);
      c1 = 8'ha8;
      if (i < 4) c1 = pwm_cfgs[8 * i +: 8];
      a = (i == 0) ? 100 : (i < 4) ? 3 : seed[7:4];
      p = (i == 0) ? 0 : (i < 4) ? 8 : 4 + seed[3:0];
      cfg(c1, a[9:0], p[9:0]);
      cyc(20);
      watch(((p == 0) ? 1024 : p) * 2, n, h);
      e = pwm_hi(c1, a, p);
      check(h[15:0], e[15:0]);
      if (i > 0 && a < p) check({fa, fp}, 16'h0003);
    end
    cfg(8'hb8, 10'd6, 10'd0);
    cyc(2);
    check(pin, 1'b1);
    cyc(20);
    check({fa, pin}, 16'h0002);
    rd_reg(3'h0, v);
    check(v, 16'h0010);
    wr_reg(3'h0, 8'h60);
    @(posedge mclk);
    ext <= 1'b1;
    cyc(4);
    rd_reg(3'h0, v);
    check({v, 7'h00, pin}, 16'h6801);
    give_verdict;
  end
endmodule
bind ptmr_core ptmr_props ptmr_props_i (.MCLK(MCLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .TIMER_OUT(TIMER_OUT), .TIMER_OUT_EN(TIMER_OUT_EN), .MATCH_A_FLAG(MATCH_A_FLAG),
  .PERIOD_MATCH_FLAG(PERIOD_MATCH_FLAG), .FLAG_CLR_A(FLAG_CLR_A));

// *** src/ptmr_core.v ***
`timescale 1ns/1ps
`include "ptmr_defs.vh"

// *****************************************************************
// Overview of operation
// *****************************************************************
module ptmr_core #(
  parameter CW = 10
) (
  input wire MCLK,
  input wire RST,
  input wire CE,
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire SUB_TICK,
  input wire EXT_COUNT_PIN,
  output reg TIMER_OUT,
  output wire TIMER_OUT_EN,
  output wire MATCH_A_FLAG,
  output wire PERIOD_MATCH_FLAG,
  input wire FLAG_CLR_A,
  input wire FLAG_CLR_P
);
  // *****************************************************************
  // Registers
  // *****************************************************************
  reg [7:0] ctrl0_q;
  reg [7:0] ctrl1_q;
  reg [CW-1:0] cnt_q;
  reg [CW-1:0] cnt_d;
  reg [CW-1:0] match_a_value_q;
  reg [CW-1:0] period_value_q;
  reg run_prev_q;
  reg pin_q;
  reg pin_d;
  reg maf_q;
  reg mpf_q;
  reg maf_set;
  reg mpf_set;
  reg hw_stop;

  wire pause = ctrl0_q[`PTMR_C0_PAUSE];
  wire counter_run = ctrl0_q[`PTMR_C0_RUN];
  wire [1:0] mode = ctrl1_q[`PTMR_C1_MODE_HI:`PTMR_C1_MODE_LO];
  wire [1:0] pin_function = ctrl1_q[`PTMR_C1_FUNC_HI:`PTMR_C1_FUNC_LO];
  wire output_initial_level = ctrl1_q[`PTMR_C1_INIT];
  wire output_invert = ctrl1_q[`PTMR_C1_INV];
  wire clear_source_select = ctrl1_q[`PTMR_C1_CLRSEL];

  wire is_pwm_grp = (mode == `PTMR_MODE_PWM);
  wire is_single = is_pwm_grp && (pin_function == `PTMR_FN_11);
  wire is_pwm = is_pwm_grp && !is_single;
  wire is_cmp = (mode == `PTMR_MODE_CMP) || (mode == `PTMR_MODE_TMR);
  // Clear select only matters in compare and timer modes.
  wire use_a_clear = is_cmp && clear_source_select;

  wire tick;
  wire pin_edge;
  wire [CW-1:0] cnt_max = {CW{1'b1}};

  ptmr_tick u_tick (
    .MCLK(MCLK),
    .RST(RST),
    .CE(CE),
    .SEL(ctrl0_q[`PTMR_C0_CLK_HI:`PTMR_C0_CLK_LO]),
    .SUB_TICK(SUB_TICK),
    .PIN(EXT_COUNT_PIN),
    .TICK(tick),
    .PIN_EDGE(pin_edge)
  );

  wire run_rise = counter_run && !run_prev_q;
  wire counting = counter_run && !pause && tick && !run_rise;
  wire match_a = counting && (cnt_q == match_a_value_q);
  wire match_p = counting && (cnt_q == period_value_q);
  // In single pulse mode, a pin edge sets the enable bit.
  wire pin_start = is_single && !counter_run && pin_edge;

  // *****************************************************************
  // Counter and flags
  // *****************************************************************
  always @* begin
    cnt_d = cnt_q;
    maf_set = 1'b0;
    mpf_set = 1'b0;
    hw_stop = 1'b0;
    if (run_rise) begin
      cnt_d = {CW{1'b0}};
    end else if (counting) begin
      cnt_d = cnt_q + {{(CW-1){1'b0}}, 1'b1};
      if (is_cmp) begin
        // A zero match value never matches, so under match A clear the counter runs to 3FF.
        if (match_a && (match_a_value_q != {CW{1'b0}})) begin
          maf_set = 1'b1;
        end
        if (use_a_clear) begin
          if (match_a && (match_a_value_q != {CW{1'b0}})) begin
            cnt_d = {CW{1'b0}};
          end else if (cnt_q == cnt_max) begin
            cnt_d = {CW{1'b0}};
          end
        end else begin
          if (match_p && (period_value_q != {CW{1'b0}})) begin
            cnt_d = {CW{1'b0}};
            mpf_set = 1'b1;
          end else if (cnt_q == cnt_max) begin
            cnt_d = {CW{1'b0}};
            mpf_set = (period_value_q == {CW{1'b0}});
          end
        end
      end else if (is_single) begin
        if (match_a) begin
          hw_stop = 1'b1;
          maf_set = 1'b1;
        end
      end else begin
        // PWM and capture: the period comparator sets the wrap.
        maf_set = match_a;
        if (period_value_q == {CW{1'b0}}) begin
          if (cnt_q == cnt_max) begin
            cnt_d = {CW{1'b0}};
            mpf_set = 1'b1;
          end
        end else if (cnt_q == period_value_q - {{(CW-1){1'b0}}, 1'b1}) begin
          // Clearing one count early makes the period exactly the period value.
          cnt_d = {CW{1'b0}};
          mpf_set = 1'b1;
        end
      end
    end
  end

  // *****************************************************************
  // Output pin
  // *****************************************************************
  wire pwm_active = (period_value_q != {CW{1'b0}} && match_a_value_q >= period_value_q) ||
    (cnt_d < match_a_value_q);

  always @* begin
    pin_d = pin_q;
    if (run_rise || pin_start) begin
      pin_d = output_initial_level;
    end else if (is_cmp) begin
      if (match_a && match_a_value_q != {CW{1'b0}}) begin
        case (pin_function)
          `PTMR_FN_01: pin_d = 1'b0;
          `PTMR_FN_10: pin_d = 1'b1;
          `PTMR_FN_11: pin_d = ~pin_q;
          default: pin_d = pin_q;
        endcase
      end
    end else if (is_pwm) begin
      case (pin_function)
        `PTMR_FN_00: pin_d = ~output_initial_level;
        `PTMR_FN_01: pin_d = output_initial_level;
        default: pin_d = pwm_active ? output_initial_level : ~output_initial_level;
      endcase
    end else if (is_single) begin
      if (hw_stop || (!counter_run && run_prev_q)) begin
        pin_d = ~output_initial_level;
      end
    end
  end

  // *****************************************************************
  // Sequential state
  // *****************************************************************
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl0_q <= `PTMR_RESET_BYTE;
      ctrl1_q <= `PTMR_RESET_BYTE;
      cnt_q <= {CW{1'b0}};
      match_a_value_q <= {CW{1'b0}};
      period_value_q <= {CW{1'b0}};
      run_prev_q <= 1'b0;
      pin_q <= 1'b0;
      maf_q <= 1'b0;
      mpf_q <= 1'b0;
    end else if (CE) begin
      cnt_q <= cnt_d;
      pin_q <= pin_d;
      run_prev_q <= counter_run;
      // Hardware set wins over a same-cycle clear.
      maf_q <= maf_set | (maf_q & ~FLAG_CLR_A);
      mpf_q <= mpf_set | (mpf_q & ~FLAG_CLR_P) ;
      if (WR && ADDR == `PTMR_ADDR_CTRL0) begin
        ctrl0_q <= {WDATA[7:3], 3'h0};
      end else if (hw_stop) begin
        ctrl0_q[`PTMR_C0_RUN] <= 1'b0;
      end else if (pin_start) begin
        ctrl0_q[`PTMR_C0_RUN] <= 1'b1;
      end
      if (WR && ADDR == `PTMR_ADDR_CTRL1) begin
        ctrl1_q <= WDATA;
      end
      if (WR && ADDR == `PTMR_ADDR_MA_LO) begin
        match_a_value_q[7:0] <= WDATA;
      end
      if (WR && ADDR == `PTMR_ADDR_MA_HI) begin
        match_a_value_q[CW-1:8] <= WDATA[CW-9:0];
      end
      if (WR && ADDR == `PTMR_ADDR_PER_LO) begin
        period_value_q[7:0] <= WDATA;
      end
      if (WR && ADDR == `PTMR_ADDR_PER_HI) begin
        period_value_q[CW-1:8] <= WDATA[CW-9:0];
      end
    end
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (CE) begin
      if (RD) begin
        case (ADDR)
          `PTMR_ADDR_CTRL0: RDATA <= ctrl0_q;
          `PTMR_ADDR_CTRL1: RDATA <= ctrl1_q;
          `PTMR_ADDR_CNT_LO: RDATA <= cnt_q[7:0];
          `PTMR_ADDR_CNT_HI: RDATA <= {{(16-CW){1'b0}}, cnt_q[CW-1:8]};
          `PTMR_ADDR_MA_LO: RDATA <= match_a_value_q[7:0];
          `PTMR_ADDR_MA_HI: RDATA <= {{(16-CW){1'b0}}, match_a_value_q[CW-1:8]};
          `PTMR_ADDR_PER_LO: RDATA <= period_value_q[7:0];
          default: RDATA <= {{(16-CW){1'b0}}, period_value_q[CW-1:8]};
        endcase
      end else begin
        RDATA <= 8'h00;
      end
    end
  end

  always @* begin
    TIMER_OUT = pin_q ^ (output_invert & ~is_cmp | output_invert & (mode == `PTMR_MODE_CMP));
  end

  // Timer/counter and capture modes release the pin.
  assign TIMER_OUT_EN = (mode == `PTMR_MODE_CMP) || is_pwm_grp;
  assign MATCH_A_FLAG = maf_q;
  assign PERIOD_MATCH_FLAG = mpf_q;
endmodule

// *** src/ptmr_defs.vh ***
`ifndef PTMR_DEFS_VH
`define PTMR_DEFS_VH

// Register addresses on the byte port.
`define PTMR_ADDR_CTRL0 3'h0
`define PTMR_ADDR_CTRL1 3'h1
`define PTMR_ADDR_CNT_LO 3'h2
`define PTMR_ADDR_CNT_HI 3'h3
`define PTMR_ADDR_MA_LO 3'h4
`define PTMR_ADDR_MA_HI 3'h5
`define PTMR_ADDR_PER_LO 3'h6
`define PTMR_ADDR_PER_HI 3'h7
`define PTMR_ADDR_STATUS 3'h0

// Control register 0 fields.
`define PTMR_C0_PAUSE 7
`define PTMR_C0_CLK_HI 6
`define PTMR_C0_CLK_LO 4
`define PTMR_C0_RUN 3

// Control register 1 fields.
`define PTMR_C1_MODE_HI 7
`define PTMR_C1_MODE_LO 6
`define PTMR_C1_FUNC_HI 5
`define PTMR_C1_FUNC_LO 4
`define PTMR_C1_INIT 3
`define PTMR_C1_INV 2
`define PTMR_C1_CAPSRC 1
`define PTMR_C1_CLRSEL 0

// Status register fields (flags cleared by the FLAG_CLR_A and FLAG_CLR_P inputs).
`define PTMR_ST_MAF 0
`define PTMR_ST_MPF 1

// Modes and functions.
`define PTMR_MODE_CMP 2'h0
`define PTMR_MODE_CAP 2'h1
`define PTMR_MODE_PWM 2'h2
`define PTMR_MODE_TMR 2'h3
`define PTMR_FN_00 2'h0
`define PTMR_FN_01 2'h1
`define PTMR_FN_10 2'h2
`define PTMR_FN_11 2'h3

// Clock source codes.
`define PTMR_CK_DIV4 3'h0
`define PTMR_CK_SYS 3'h1
`define PTMR_CK_H16 3'h2
`define PTMR_CK_H64 3'h3
`define PTMR_CK_SUB 3'h4
`define PTMR_CK_H 3'h5
`define PTMR_CK_PINR 3'h6
`define PTMR_CK_PINF 3'h7

`define PTMR_RESET_BYTE 8'h00
`define PTMR_CNT_MAX 10'h3ff
`define PTMR_DIV4 4
`define PTMR_DIV16 16
`define PTMR_DIV64 64

`endif

// *** src/ptmr_tick.v ***
`timescale 1ns/1ps
`include "ptmr_defs.vh"

// Count-clock tick generator: one-cycle tick per selected source period.
module ptmr_tick (
  input wire MCLK,
  input wire RST,
  input wire CE,
  input wire [2:0] SEL,
  input wire SUB_TICK,
  input wire PIN,
  output reg TICK,
  output wire PIN_EDGE
);
  reg [5:0] div_q;
  reg pin_q;

  // Pin taken as synchronous; edge seen against its last sample.
  assign PIN_EDGE = (SEL == `PTMR_CK_PINF) ? (pin_q & ~PIN) : (~pin_q & PIN);

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      div_q <= 6'h00;
      pin_q <= 1'b0;
    end else if (CE) begin
      div_q <= div_q + 6'h01;
      pin_q <= PIN;
    end
  end

  always @* begin
    case (SEL)
      `PTMR_CK_DIV4: TICK = (div_q[1:0] == 2'h3);
      `PTMR_CK_SYS: TICK = 1'b1;
      `PTMR_CK_H16: TICK = (div_q[3:0] == 4'hf);
      `PTMR_CK_H64: TICK = (div_q == 6'h3f);
      `PTMR_CK_SUB: TICK = SUB_TICK;
      `PTMR_CK_H: TICK = 1'b1;
      default: TICK = PIN_EDGE;
    endcase
  end
endmodule
